// ---- testbench/fsb_host_model.sv ----
// serial host model that issues command frames in clock mode 0
`timescale 1ns/1ps
module fsb_host_model (
    input wire logic i_clk,  // system clock
    input wire logic i_so,   // serial data from device
    output logic o_sck,      // serial clock, low outside frames
    output logic o_cs_n,     // chip select, active low
    output logic o_si        // serial data to device
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wait_clk
    // boot start delay is counted from this falling select
    task automatic sel();
        @(negedge i_clk);
        o_cs_n = 1'b0;
    endtask : sel
    // data changes with the falling clock, device output sampled on the rise
    task automatic shift_bit(input logic b, output logic r);
        o_si = b;
        wait_clk(4);
        o_sck = 1'b1;
        r = i_so;
        wait_clk(4);
        o_sck = 1'b0;
    endtask : shift_bit
    task automatic desel();
        wait_clk(4);
        o_cs_n = 1'b1;
        o_si = ~o_si; // deselected line must not keep its last bit
        wait_clk(8);
    endtask : desel
    // opcode byte first, then address or data bytes, all msb first
    task automatic frame(input int nb, input logic [63:0] tx, output logic [63:0] rx);
        logic r;
        rx = '0;
        sel();
        for (int i = nb * 8 - 1; i >= 0; i--) begin
            shift_bit(tx[i], r);
            rx = {rx[62:0], r};
        end
        desel();
    endtask : frame
endmodule : fsb_host_model

// ---- testbench/fsb_regs_tb_top.sv ----
// self-checking bench of the flash register bank over its serial link
`timescale 1ns/1ps
module fsb_regs_tb_top;
    logic i_clk, i_rst, i_hw_rst_n, i_sw_rst, i_sck, i_cs_n, i_si, o_so, o_so_oe_n, r;
    logic o_four_byte_mode, o_boot_active, o_boot_stream;
    logic [2:0] i_ecc_flags;
    logic [27:0] o_ecc_unit_addr;
    logic [7:0] o_upper_addr;
    logic [31:0] o_boot_addr;
    logic [63:0] rx;
    int error_cnt = 0;
    int check_count = 0;
    logic [7:0] ops [4] = '{8'h75, 8'h85, 8'h7a, 8'h8a};
    logic [7:0] sts [4] = '{8'h02, 8'h03, 8'h01, 8'h00};
    logic [2:0] flg [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    fsb_regs i_fsb_regs (.i_clk(i_clk), .i_rst(i_rst), .i_hw_rst_n(i_hw_rst_n), .i_sw_rst(i_sw_rst),
        .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_ecc_flags(i_ecc_flags), .o_so(o_so),
        .o_so_oe_n(o_so_oe_n), .o_ecc_unit_addr(o_ecc_unit_addr), .o_upper_addr(o_upper_addr),
        .o_four_byte_mode(o_four_byte_mode), .o_boot_active(o_boot_active),
        .o_boot_stream(o_boot_stream), .o_boot_addr(o_boot_addr));
    fsb_host_model i_fsb_host_model (.i_clk(i_clk), .i_so(o_so), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xf(input int nb, input logic [63:0] tx);
        i_fsb_host_model.frame(nb, tx, rx);
    endtask : xf
    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #3_000_000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        i_rst = 1'b1;
        i_hw_rst_n = 1'b1;
        i_sw_rst = 1'b0;
        i_ecc_flags = 3'h0;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        i_fsb_host_model.wait_clk(4);
        chk(64'({o_four_byte_mode, o_boot_active, o_so_oe_n}), 64'h1);
        xf(2, 64'h07_00);
        chk(64'(rx[7:0]), 64'h00);
        for (int k = 0; k < 4; k++) begin
            xf(1, 64'(ops[k]));
            xf(2, 64'h07_ff);
            chk(64'(rx[7:0]), 64'(sts[k]));
        end
        xf(5, 64'h14_0000_0000);
        chk(64'(rx[31:0]), 64'h0);
        xf(5, 64'h15_1234_5a05);
        xf(5, 64'h14_0000_0000);
        chk(64'(rx[31:0]), 64'h1234_5a05);
        chk(64'(o_boot_addr), 64'h1234_5a00);
        i_sw_rst = 1'b1;
        i_fsb_host_model.wait_clk(1);
        i_sw_rst = 1'b0;
        i_fsb_host_model.wait_clk(4);
        chk(64'(o_boot_active), 64'h1);
        i_fsb_host_model.sel();
        i_fsb_host_model.shift_bit(1'b0, r);
        i_fsb_host_model.wait_clk(2);
        chk(64'(o_boot_stream), 64'h0);
        i_fsb_host_model.shift_bit(1'b0, r);
        i_fsb_host_model.wait_clk(2);
        chk(64'(o_boot_stream), 64'h1);
        i_fsb_host_model.desel();
        chk(64'({o_boot_active, o_boot_stream}), 64'h0);
        xf(5, 64'h15_1234_5a00);
        xf(2, 64'h17_ff);
        xf(2, 64'h16_00);
        chk(64'(rx[7:0]), 64'h80);
        chk(64'({o_four_byte_mode, o_upper_addr}), 64'h100);
        i_ecc_flags = 3'h5;
        xf(6, 64'h18_0000_1230_00);
        chk(64'(o_ecc_unit_addr), 64'h123);
        chk(64'(rx[2:0]), 64'h5);
        xf(2, 64'h17_00);
        chk(64'(o_four_byte_mode), 64'h0);
        xf(1, 64'hb9);
        xf(2, 64'h01_80);
        xf(2, 64'h16_00);
        chk(64'(rx[7:0]), 64'h80);
        xf(1, 64'h75);
        i_hw_rst_n = 1'b0;
        i_fsb_host_model.wait_clk(3);
        i_hw_rst_n = 1'b1;
        i_fsb_host_model.wait_clk(8);
        chk(64'(o_four_byte_mode), 64'h0);
        xf(2, 64'h16_00);
        chk(64'(rx[7:0]), 64'h00);
        xf(2, 64'h07_00);
        chk(64'(rx[7:0]), 64'h00);
        xf(5, 64'h14_0000_0000);
        chk(64'(rx[31:0]), 64'h1234_5a00);
        for (int k = 0; k < 4; k++) begin
            i_ecc_flags = flg[k];
            xf(5, 64'h18_0012_30_00);
            chk(64'(rx[2:0]), 64'(flg[k]));
        end
        chk(64'(o_ecc_unit_addr), 64'h123);
        print_verdict();
    end
endmodule : fsb_regs_tb_top

// ---- verilog/fsb_boot_seq.sv ----
// boot-on-reset sequencer: arms after reset, counts start delay, flags streaming
`timescale 1ns/1ps
module fsb_boot_seq (
    input wire logic i_clk,          // system clock
    input wire logic i_rst,          // any reset, synchronous
    input wire logic i_enable,       // boot on reset enabled
    input wire logic [7:0] i_delay,  // start delay in serial clocks
    input wire logic i_cs_fall,      // chip select fell
    input wire logic i_cs_rise,      // chip select rose
    input wire logic i_sck_rise,     // serial clock rose
    output logic o_busy,             // boot frame pending or running
    output logic o_stream            // boot data may be shifted out
);
    fsb_pkg::fsb_boot_e state_reg;
    logic after_rst_reg;
    logic [7:0] cnt_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= fsb_pkg::BT_IDLE;
            after_rst_reg <= 1'b1;
            cnt_reg <= 8'h00;
        end else begin
            after_rst_reg <= 1'b0;
            unique case (state_reg)
                fsb_pkg::BT_IDLE: begin
                    if (after_rst_reg && i_enable) state_reg <= fsb_pkg::BT_ARMED;
                end
                fsb_pkg::BT_ARMED: begin
                    cnt_reg <= 8'h00;
                    if (i_cs_fall) begin
                        state_reg <= (i_delay == 8'h00) ? fsb_pkg::BT_STREAM : fsb_pkg::BT_DELAY;
                    end
                end
                fsb_pkg::BT_DELAY: begin
                    if (i_cs_rise) state_reg <= fsb_pkg::BT_IDLE;
                    else if (i_sck_rise) begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg + 8'h01 == i_delay) state_reg <= fsb_pkg::BT_STREAM;
                    end
                end
                fsb_pkg::BT_STREAM: begin
                    if (i_cs_rise) state_reg <= fsb_pkg::BT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_stream <= 1'b0;
        end else begin
            o_busy <= (state_reg != fsb_pkg::BT_IDLE) && !i_cs_rise;
            o_stream <= (state_reg == fsb_pkg::BT_STREAM) && !i_cs_rise;
        end
    end
endmodule : fsb_boot_seq

// ---- verilog/fsb_link_if.sv ----
// serial link signals between the pin shifter and the command core
`timescale 1ns/1ps
interface fsb_link_if;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic [7:0] tx_byte;
    logic tx_load;
    modport shifter (output rx_byte, rx_valid, cs_fall, cs_rise, sck_rise, input tx_byte, tx_load);
    modport core (input rx_byte, rx_valid, cs_fall, cs_rise, sck_rise, output tx_byte, tx_load);
endinterface : fsb_link_if

// ---- verilog/fsb_map.svh ----
// register layout, command codes and reset values of the flash register bank
`ifndef FSB_MAP_SVH
`define FSB_MAP_SVH
`define FSB_OP_RD_SUSP 8'h07
`define FSB_OP_REG_WR 8'h01
`define FSB_OP_BOOT_RD 8'h14
`define FSB_OP_BOOT_WR 8'h15
`define FSB_OP_BANK_RD 8'h16
`define FSB_OP_BANK_WR 8'h17
`define FSB_OP_BANK_ACC 8'hb9
`define FSB_OP_ECC_RD 8'h18
`define FSB_OP_ERS_PAUSE 8'h75
`define FSB_OP_ERS_GO 8'h7a
`define FSB_OP_PGM_PAUSE 8'h85
`define FSB_OP_PGM_GO 8'h8a
`define FSB_SUSP_ERASE_BIT 1
`define FSB_SUSP_PROG_BIT 0
`define FSB_SUSP_RST 8'h00
`define FSB_BOOT_EN_BIT 0
`define FSB_BOOT_DLY_LSB 1
`define FSB_BOOT_DLY_MSB 8
`define FSB_BOOT_ADDR_LSB 9
`define FSB_BOOT_RST 32'h0000_0000
`define FSB_BANK_EXT_BIT 7
`define FSB_BANK_RST 8'h00
`define FSB_BANK_WMASK 8'h80
`define FSB_ECC_UNIT_LSB 4
`define FSB_ECC_RSVD 5'h00
`define FSB_ECC_ALEN3 3'h3
`define FSB_ECC_ALEN4 3'h4
`endif

// ---- verilog/fsb_pkg.sv ----
// shared types of the flash register bank
package fsb_pkg;
    typedef logic [7:0] fsb_byte_t;
    typedef enum logic [1:0] {
        ST_OPC = 2'b00,
        ST_BODY = 2'b01,
        ST_SKIP = 2'b10
    } fsb_cmd_e;
    typedef enum logic [1:0] {
        BT_IDLE = 2'b00,
        BT_ARMED = 2'b01,
        BT_DELAY = 2'b10,
        BT_STREAM = 2'b11
    } fsb_boot_e;
endpackage : fsb_pkg

// ---- verilog/fsb_regs.sv ----
// command-accessed suspend, boot, bank and correction status registers
`timescale 1ns/1ps
`include "fsb_map.svh"
module fsb_regs (
    input wire logic i_clk,                 // system clock, 10 MHz
    input wire logic i_rst,                 // power-on reset, synchronous
    input wire logic i_hw_rst_n,            // hardware reset pin, active low
    input wire logic i_sw_rst,              // software reset pulse, same clock
    input wire logic i_sck,                 // serial clock pin
    input wire logic i_cs_n,                // chip select pin, active low
    input wire logic i_si,                  // serial data in pin
    input wire logic [2:0] i_ecc_flags,     // status of the selected unit
    output logic o_so,                      // serial data out
    output logic o_so_oe_n,                 // data out enable, low drives
    output logic [27:0] o_ecc_unit_addr,    // selected correction unit
    output logic [7:0] o_upper_addr,        // address bits above A23
    output logic o_four_byte_mode,          // four-byte address mode
    output logic o_boot_active,             // boot frame pending or running
    output logic o_boot_stream,             // boot data transfer started
    output logic [31:0] o_boot_addr         // boot code start address
);
    fsb_link_if lk ();
    fsb_pkg::fsb_cmd_e state_reg;
    fsb_pkg::fsb_byte_t opcode_reg;
    fsb_pkg::fsb_byte_t susp_status;
    logic [2:0] cnt_reg;
    logic [1:0] hw_reg;
    logic vrst;
    logic erase_paused_flag;
    logic program_paused_flag;
    logic [31:0] boot_cfg_reg;
    logic [23:0] boot_sh_reg;
    logic [7:0] bank_reg;
    logic bank_armed_reg;
    logic wr_via_reg;
    logic [31:0] ecc_addr_reg;
    logic ecc_pend_reg;
    logic ecc_pend_next;
    logic tx_go;
    logic [7:0] tx_val;
    logic boot_busy;
    logic boot_stream;
    logic opc_strobe;
    logic body_strobe;
    logic [2:0] ecc_alen;

    // ***************
    // helpers
    // ***************
    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx[1:0])
            2'h0: b = w[31:24];
            2'h1: b = w[23:16];
            2'h2: b = w[15:8];
            2'h3: b = w[7:0];
        endcase
        return b;
    endfunction : word_byte

    function automatic logic [7:0] bank_merge(input logic [7:0] old, input logic [7:0] nw);
        return (nw & `FSB_BANK_WMASK) | (old & ~`FSB_BANK_WMASK);
    endfunction : bank_merge

    // ***************
    // resets
    // ***************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hw_reg <= 2'h3;
        end else begin
            hw_reg <= {hw_reg[0], i_hw_rst_n};
        end
    end
    assign vrst = i_rst | ~hw_reg[1] | i_sw_rst;

    // ***************
    // link and boot sequencer
    // ***************
    fsb_spi_shifter u_shifter (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .lk(lk.shifter),
        .o_so(o_so),
        .o_so_oe_n(o_so_oe_n)
    );

    fsb_boot_seq u_boot (
        .i_clk(i_clk),
        .i_rst(vrst),
        .i_enable(boot_cfg_reg[`FSB_BOOT_EN_BIT]),
        .i_delay(boot_cfg_reg[`FSB_BOOT_DLY_MSB:`FSB_BOOT_DLY_LSB]),
        .i_cs_fall(lk.cs_fall),
        .i_cs_rise(lk.cs_rise),
        .i_sck_rise(lk.sck_rise),
        .o_busy(boot_busy),
        .o_stream(boot_stream)
    );

    // ***************
    // command framing
    // ***************
    assign opc_strobe = lk.rx_valid && (state_reg == fsb_pkg::ST_OPC);
    assign body_strobe = lk.rx_valid && (state_reg == fsb_pkg::ST_BODY);
    assign ecc_alen = o_four_byte_mode ? `FSB_ECC_ALEN4 : `FSB_ECC_ALEN3;

    always_ff @(posedge i_clk) begin
        if (vrst) begin
            state_reg <= fsb_pkg::ST_SKIP;
            opcode_reg <= 8'h00;
            cnt_reg <= 3'h0;
        end else if (lk.cs_fall) begin
            state_reg <= boot_busy ? fsb_pkg::ST_SKIP : fsb_pkg::ST_OPC;
            cnt_reg <= 3'h0;
        end else if (opc_strobe) begin
            state_reg <= fsb_pkg::ST_BODY;
            opcode_reg <= lk.rx_byte;
        end else if (body_strobe && cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    // ***************
    // suspend status
    // ***************
    always_ff @(posedge i_clk) begin
        if (vrst) begin
            erase_paused_flag <= 1'b0;
            program_paused_flag <= 1'b0;
        end else if (opc_strobe) begin
            if (lk.rx_byte == `FSB_OP_ERS_PAUSE) erase_paused_flag <= 1'b1;
            if (lk.rx_byte == `FSB_OP_ERS_GO) erase_paused_flag <= 1'b0;
            if (lk.rx_byte == `FSB_OP_PGM_PAUSE) program_paused_flag <= 1'b1;
            if (lk.rx_byte == `FSB_OP_PGM_GO) program_paused_flag <= 1'b0;
        end
    end

    always_comb begin
        susp_status = `FSB_SUSP_RST;
        susp_status[`FSB_SUSP_ERASE_BIT] = erase_paused_flag;
        susp_status[`FSB_SUSP_PROG_BIT] = program_paused_flag;
    end

    // ***************
    // boot configuration, kept over hardware and software reset
    // ***************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            boot_cfg_reg <= `FSB_BOOT_RST;
            boot_sh_reg <= 24'h000000;
        end else if (body_strobe && opcode_reg == `FSB_OP_BOOT_WR) begin
            boot_sh_reg <= {boot_sh_reg[15:0], lk.rx_byte};
            if (cnt_reg == 3'h3) boot_cfg_reg <= {boot_sh_reg, lk.rx_byte};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_boot_addr <= 32'h0000_0000;
            o_boot_active <= 1'b0;
            o_boot_stream <= 1'b0;
        end else begin
            o_boot_addr <= {boot_cfg_reg[31:`FSB_BOOT_ADDR_LSB], 9'h000};
            o_boot_active <= boot_busy;
            o_boot_stream <= boot_stream;
        end
    end

    // ***************
    // bank register
    // ***************
    always_ff @(posedge i_clk) begin
        if (vrst) begin
            bank_reg <= `FSB_BANK_RST;
            bank_armed_reg <= 1'b0;
            wr_via_reg <= 1'b0;
        end else if (opc_strobe) begin
            bank_armed_reg <= (lk.rx_byte == `FSB_OP_BANK_ACC);
            wr_via_reg <= bank_armed_reg && (lk.rx_byte == `FSB_OP_REG_WR);
        end else if (body_strobe && cnt_reg == 3'h0) begin
            if (opcode_reg == `FSB_OP_BANK_WR || (opcode_reg == `FSB_OP_REG_WR && wr_via_reg)) begin
                bank_reg <= bank_merge(bank_reg, lk.rx_byte);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (vrst) begin
            o_four_byte_mode <= 1'b0;
            o_upper_addr <= 8'h00;
        end else begin
            o_four_byte_mode <= bank_reg[`FSB_BANK_EXT_BIT];
            o_upper_addr <= bank_reg[`FSB_BANK_EXT_BIT] ? 8'h00 : {1'b0, bank_reg[6:0]};
        end
    end

    // ***************
    // correction status read
    // ***************
    assign ecc_pend_next = body_strobe && opcode_reg == `FSB_OP_ECC_RD && ({1'b0, cnt_reg} + 4'h1 >= {1'b0, ecc_alen});

    always_ff @(posedge i_clk) begin
        if (vrst) begin
            ecc_addr_reg <= 32'h0000_0000;
            o_ecc_unit_addr <= 28'h0000000;
            ecc_pend_reg <= 1'b0;
        end else begin
            ecc_pend_reg <= ecc_pend_next;
            if (body_strobe && opcode_reg == `FSB_OP_ECC_RD && cnt_reg < ecc_alen) begin
                ecc_addr_reg <= {ecc_addr_reg[23:0], lk.rx_byte};
                if (cnt_reg + 3'h1 == ecc_alen) begin
                    // unit index is the full byte address without its low nibble
                    o_ecc_unit_addr <= o_four_byte_mode ?
                        {ecc_addr_reg[23:0], lk.rx_byte[7:`FSB_ECC_UNIT_LSB]} :
                        {o_upper_addr, ecc_addr_reg[15:0], lk.rx_byte[7:`FSB_ECC_UNIT_LSB]};
                end
            end
        end
    end

    // ***************
    // read data
    // ***************
    always_comb begin
        tx_go = 1'b0;
        tx_val = 8'h00;
        if (opc_strobe) begin
            unique case (lk.rx_byte)
                `FSB_OP_RD_SUSP: begin
                    tx_go = 1'b1;
                    tx_val = susp_status;
                end
                `FSB_OP_BOOT_RD: begin
                    tx_go = 1'b1;
                    tx_val = word_byte(boot_cfg_reg, 3'h0);
                end
                `FSB_OP_BANK_RD: begin
                    tx_go = 1'b1;
                    tx_val = bank_reg;
                end
                default: tx_go = 1'b0;
            endcase
        end else if (body_strobe) begin
            unique case (opcode_reg)
                `FSB_OP_RD_SUSP: begin
                    tx_go = 1'b1;
                    tx_val = susp_status;
                end
                `FSB_OP_BOOT_RD: begin
                    tx_go = 1'b1;
                    tx_val = word_byte(boot_cfg_reg, cnt_reg + 3'h1);
                end
                `FSB_OP_BANK_RD: begin
                    tx_go = 1'b1;
                    tx_val = bank_reg;
                end
                default: tx_go = 1'b0;
            endcase
        end else if (ecc_pend_reg) begin
            tx_go = 1'b1;
            tx_val = {`FSB_ECC_RSVD, i_ecc_flags};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lk.tx_load <= 1'b0;
            lk.tx_byte <= 8'h00;
        end else begin
            lk.tx_load <= tx_go;
            lk.tx_byte <= tx_val;
        end
    end

    // ***************
    // assertions
    // ***************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_ERASE_PAUSE: assert property (opc_strobe && lk.rx_byte == `FSB_OP_ERS_PAUSE && !vrst
        |=> susp_status[1]) else $error("erase pause flag not set");
    AST_ERASE_GO: assert property (opc_strobe && lk.rx_byte == `FSB_OP_ERS_GO
        |=> !susp_status[1]) else $error("erase pause flag not cleared");
    AST_PROG_PAUSE: assert property (opc_strobe && lk.rx_byte == `FSB_OP_PGM_PAUSE && !vrst
        |=> susp_status[0] && $stable(susp_status[1])) else $error("program pause flag wrong");
    AST_SUSP_RSVD: assert property (lk.tx_load && opcode_reg == `FSB_OP_RD_SUSP
        |-> lk.tx_byte[7:2] == 6'h00) else $error("suspend reserved bits not zero");
    AST_FOUR_BYTE_RST: assert property (vrst |=> !o_four_byte_mode ##1 !o_four_byte_mode)
        else $error("four-byte mode survived reset");
    AST_UPPER_IGNORED: assert property (o_four_byte_mode |-> o_upper_addr == 8'h00)
        else $error("bank bits used in four-byte mode");
    AST_UPPER_BANK: assert property (!vrst && !bank_reg[7] ##1 !vrst
        |-> o_upper_addr == {1'b0, $past(bank_reg[6:0])}) else $error("upper address does not follow bank");
    AST_BANK_RSVD: assert property ((bank_reg & ~`FSB_BANK_WMASK) == 8'h00)
        else $error("reserved bank bits set");
    AST_BOOT_WR: assert property (body_strobe && opcode_reg == `FSB_OP_BOOT_WR && cnt_reg == 3'h3
        |=> boot_cfg_reg[7:0] == $past(lk.rx_byte)) else $error("boot configuration not written");
    AST_ECC_STATUS: assert property (ecc_pend_reg && !vrst
        |=> lk.tx_load && lk.tx_byte == {5'h00, $past(i_ecc_flags)}) else $error("correction status not returned");
    AST_BOOT_ADDR: assert property (!vrst ##1 !vrst |-> o_boot_addr[8:0] == 9'h000)
        else $error("boot address not aligned");

    COV_SUSP_READ: cover property (opc_strobe && lk.rx_byte == `FSB_OP_RD_SUSP ##[1:40] lk.tx_load);
    COV_BANK_VIA_REG: cover property (wr_via_reg && body_strobe && opcode_reg == `FSB_OP_REG_WR);
    COV_ECC_READ: cover property (ecc_pend_reg);
    COV_BOOT_STREAM: cover property (o_boot_stream);
endmodule : fsb_regs

// ---- verilog/fsb_spi_shifter.sv ----
// pin synchronisers, edge detection and byte shifter of the serial link
`timescale 1ns/1ps
module fsb_spi_shifter (
    input wire logic i_clk,      // system clock
    input wire logic i_rst,      // synchronous reset
    input wire logic i_sck,      // serial clock pin
    input wire logic i_cs_n,     // chip select pin
    input wire logic i_si,       // serial data in pin
    fsb_link_if.shifter lk,      // to command core
    output logic o_so,           // serial data out
    output logic o_so_oe_n       // data out enable, low drives
);
    logic [2:0] sck_reg;
    logic [2:0] cs_reg;
    logic [1:0] si_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic sck_fall;

    // ***************
    // synchronisers
    // ***************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sck_reg <= 3'h0;
            cs_reg <= 3'h7;
            si_reg <= 2'h0;
        end else begin
            sck_reg <= {sck_reg[1:0], i_sck};
            cs_reg <= {cs_reg[1:0], i_cs_n};
            si_reg <= {si_reg[0], i_si};
        end
    end

    assign lk.sck_rise = sck_reg[1] & ~sck_reg[2] & ~cs_reg[1];
    assign sck_fall = ~sck_reg[1] & sck_reg[2] & ~cs_reg[1];
    assign lk.cs_fall = ~cs_reg[1] & cs_reg[2];
    assign lk.cs_rise = cs_reg[1] & ~cs_reg[2];

    // ***************
    // receive, msb first
    // ***************
    always_ff @(posedge i_clk) begin
        if (i_rst || lk.cs_fall) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            lk.rx_valid <= 1'b0;
        end else begin
            lk.rx_valid <= lk.sck_rise && (bit_cnt_reg == 3'h7);
            if (lk.sck_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                rx_sh_reg <= {rx_sh_reg[6:0], si_reg[1]};
            end
        end
    end
    assign lk.rx_byte = rx_sh_reg;

    // ***************
    // transmit, msb first on falling edges
    // ***************
    always_ff @(posedge i_clk) begin
        if (i_rst || lk.cs_rise) begin
            tx_sh_reg <= 8'h00;
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
        end else if (lk.tx_load) begin
            tx_sh_reg <= lk.tx_byte;
        end else if (sck_fall) begin
            o_so <= tx_sh_reg[7];
            o_so_oe_n <= 1'b0;
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end
endmodule : fsb_spi_shifter
